// ---- tb/testbench.sv ----
// Self-checking bench for the sequencer argument decoder
`timescale 1ns/10ps
module testbench;
    logic sys_clk_i = 1'b0, arst_n_i = 1'b0, step_valid_i = 1'b0, lvl = 1'b0;
    logic [3:0] step_opcode_i = 4'h0, step_arg_i = 4'h0, sel = 4'h0;
    wire pwm_special_evt_i, pwm_tb_sync_i, capture_unit_1_evt_i, adc_done_i;
    wire ext_interrupt_pin_2_i, step_done_o;
    wire [2:0] pwm_gen_irq_i;
    wire [1:0] compare_unit_evt_i, pwm_tb_src_o, cmp_blank_mask_o, pin_remap_select_o;
    wire [3:0] analog_comparator_evt_i, seq_irq_o, compare_sync_o, compare_clk_o;
    wire [3:0] capture_sync_o, adc_sample_trig_o;
    wire [31:0] seq_trigger_out_o;
    int mismatches = 0;
    int samples_checked = 0;
    tsq_option_decode dut (.*);
    tsq_evt_model pm (.*);
    always #10 sys_clk_i = ~sys_clk_i;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Present a step and hold it through the taking edge
    task automatic step(input logic [3:0] op, input logic [3:0] arg);
        step_valid_i = 1'b1;
        step_opcode_i = op;
        step_arg_i = arg;
        @(posedge sys_clk_i) #1;
    endtask
    // All 32 trigger indices back to back, then the pulse ends
    task automatic t_trig;
        for (int i = 0; i < 32; i++) begin
            step({3'h4, i[4]}, i[3:0]);
            check(seq_trigger_out_o, (i > 19 && i < 30) ? 32'h0 : 32'h1 << i);
            check(step_done_o, 1'b1);
        end
        step_valid_i = 1'b0;
        @(posedge sys_clk_i) #1;
        check(seq_trigger_out_o, 32'h0);
    endtask
    // Every interrupt argument, reserved ones give done only
    task automatic t_irq;
        for (int a = 0; a < 16; a++) begin
            step(4'h7, a[3:0]);
            check(seq_irq_o, a < 4 ? 4'h1 << a : 4'h0);
            check(step_done_o, 1'b1);
        end
        step_valid_i = 1'b0;
    endtask
    // Wait on one source for the edge that toggling the level makes
    task automatic wait_edge(input logic [3:0] op, input logic [3:0] k);
        int n;
        n = 0;
        step(op, k);
        step_valid_i = 1'b0;
        if (k == 4'h5 || k == 4'h6) begin
            check(step_done_o, 1'b1);
            return;
        end
        repeat (4) begin
            check(step_done_o, 1'b0);
            @(posedge sys_clk_i) #1;
        end
        lvl = ~lvl;
        while (step_done_o !== 1'b1 && n < 8) begin
            @(posedge sys_clk_i) #1;
            n++;
        end
        check(step_done_o, 1'b1);
        if (step_done_o !== 1'b1) conclude();
    endtask
    task automatic t_wait;
        for (int k = 0; k < 16; k++) begin
            sel = k[3:0];
            repeat (4) @(posedge sys_clk_i) #1;
            wait_edge(4'h4, k[3:0]);
            wait_edge(4'h5, k[3:0]);
        end
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_i);
        #1 arst_n_i = 1'b1;
        repeat (4) @(posedge sys_clk_i) #1;
        t_trig();
        t_irq();
        t_wait();
        conclude();
    end
endmodule // testbench
bind tsq_option_decode tsq_decode_properties chk (.*);

// ---- tb/tsq_decode_properties.sv ----
// Port assertions for the sequencer argument decoder
`timescale 1ns/10ps
module tsq_decode_properties (
    // Clock, reset and step
    input logic sys_clk_i, arst_n_i, step_valid_i, step_done_o,
    input logic [3:0] step_opcode_i, step_arg_i, seq_irq_o,
    // Trigger vector and fan-out
    input logic [31:0] seq_trigger_out_o,
    input logic [3:0] compare_sync_o, compare_clk_o, capture_sync_o, adc_sample_trig_o,
    input logic [1:0] pwm_tb_src_o, cmp_blank_mask_o, pin_remap_select_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Trigger index comes from the step taken one cycle earlier
    chk_trig_index: assert property (|seq_trigger_out_o |-> $past(step_valid_i) &&
        $past(step_opcode_i[3:1]) == 3'h4 &&
        seq_trigger_out_o == 32'h1 << $past({step_opcode_i[0], step_arg_i}))
        else $error("trigger index wrong");
    chk_trig_single: assert property ($onehot0(seq_trigger_out_o)) else $error("two triggers");
    chk_trig_rsv: assert property (seq_trigger_out_o[29:20] == 10'h000) else $error("rsv trig");
    chk_irq_index: assert property (|seq_irq_o |-> $past(step_opcode_i) == 4'h7 &&
        $past(step_arg_i[3:2]) == 2'h0 && seq_irq_o == 4'h1 << $past(step_arg_i[1:0]))
        else $error("interrupt index wrong");
    chk_pulse_done: assert property (|{seq_irq_o, seq_trigger_out_o} |-> step_done_o)
        else $error("pulse without done");
    // Named fan-out mirrors the vector
    chk_cmp_fan: assert property ({compare_clk_o, compare_sync_o} == seq_trigger_out_o[7:0])
        else $error("compare fan-out");
    chk_cap_adc: assert property ({adc_sample_trig_o, capture_sync_o} == seq_trigger_out_o[15:8])
        else $error("capture or sample fan-out");
    chk_pwm_mask: assert property ({cmp_blank_mask_o, pwm_tb_src_o} == seq_trigger_out_o[19:16])
        else $error("pwm or mask fan-out");
    chk_remap_fan: assert property (pin_remap_select_o == seq_trigger_out_o[31:30])
        else $error("remap fan-out");
endmodule // tsq_decode_properties

// ---- tb/tsq_evt_model.sv ----
// Peripheral event sources facing the decoder
`timescale 1ns/10ps
module tsq_evt_model (
    // Selected source and its level
    input logic [3:0] sel,
    input logic lvl,
    // Event lines
    output logic pwm_special_evt_i, pwm_tb_sync_i, capture_unit_1_evt_i, adc_done_i,
    output logic ext_interrupt_pin_2_i,
    output logic [2:0] pwm_gen_irq_i,
    output logic [1:0] compare_unit_evt_i,
    output logic [3:0] analog_comparator_evt_i
);
    // Only the selected source follows the level, others stay low
    logic [15:0] ev;
    assign ev = {15'h0000, lvl} << sel;
    assign pwm_special_evt_i = ev[0];
    assign pwm_tb_sync_i = ev[1];
    assign pwm_gen_irq_i = ev[4:2];
    assign compare_unit_evt_i = ev[8:7];
    assign capture_unit_1_evt_i = ev[9];
    assign analog_comparator_evt_i = ev[13:10];
    assign adc_done_i = ev[14];
    assign ext_interrupt_pin_2_i = ev[15];
endmodule // tsq_evt_model

// ---- verilog/tsq_decode_map.vh ----
// Constants for the trigger sequencer argument decoder
// Behaviour
// - Edge-wait argument 0000 picks special event trigger
// - Edge-wait argument 0001 picks time base sync
// - Remaining edge-wait arguments map to listed events
// - Wait commands stall until selected edge arrives
// - Interrupt arguments 0000-0011 raise interrupts 0-3
// - Reserved arguments complete as no-operation steps
// - Trigger index is opcode bit0 with argument
// - Outputs 0-3 sync compare units 1-4
// - Outputs 4-7 clock compare units 1-4
// - Outputs 8-11 sync capture units 1-4
// - Outputs 12-15 are converter sample triggers
// - Outputs 16-17 are PWM time base sources
// - Outputs 18-19 feed comparator blanking masks
// - Outputs 30-31 feed pin remap selection
`ifndef TSQ_DECODE_MAP_VH
`define TSQ_DECODE_MAP_VH
`define TSQ_OP_WAIT_RISE 4'h4
`define TSQ_OP_WAIT_FALL 4'h5
`define TSQ_OP_IRQ 4'h7
`define TSQ_OP_TRIG_HI 3'h4
`define TSQ_ARG_SPECIAL_EVT 4'h0
`define TSQ_ARG_TB_SYNC 4'h1
`define TSQ_ARG_PWM1 4'h2
`define TSQ_ARG_PWM2 4'h3
`define TSQ_ARG_PWM3 4'h4
`define TSQ_ARG_RSV5 4'h5
`define TSQ_ARG_RSV6 4'h6
`define TSQ_ARG_CMP_UNIT1 4'h7
`define TSQ_ARG_CMP_UNIT2 4'h8
`define TSQ_ARG_CAP_UNIT1 4'h9
`define TSQ_ARG_ACMP1 4'hA
`define TSQ_ARG_ACMP2 4'hB
`define TSQ_ARG_ACMP3 4'hC
`define TSQ_ARG_ACMP4 4'hD
`define TSQ_ARG_ADC_DONE 4'hE
`define TSQ_ARG_EXT_EXT_INTERRUPT_PIN_2 4'hF
`define TSQ_IRQ_LAST 4'h3
`define TSQ_TRIG_RSV_LO 5'h14
`define TSQ_TRIG_RSV_HI 5'h1D
`define TSQ_SYNC_RESET 3'h0
`endif

// ---- verilog/tsq_edge_detect.v ----
// Pin synchroniser and edge detector for one sequencer event input
`timescale 1ns/10ps
`include "tsq_decode_map.vh"
module tsq_edge_detect (
    // Clock and reset
    input wire sys_clk_i,
    input wire arst_n_i,
    // Raw event input
    input wire evt_i,
    // Edge pulses of the synchronised input
    output wire rise_o,
    output wire fall_o
);
    reg [2:0] sync_r;

    // Three stages; edges judged on stages two and three only
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_r <= `TSQ_SYNC_RESET;
        end else begin
            sync_r <= {sync_r[1:0], evt_i};
        end
    end

    assign rise_o = sync_r[1] & ~sync_r[2];
    assign fall_o = ~sync_r[1] & sync_r[2];
endmodule // tsq_edge_detect

// ---- verilog/tsq_option_decode.v ----
// Trigger sequencer argument decoder, edge waits and output fan-out
`timescale 1ns/10ps
`include "tsq_decode_map.vh"
module tsq_option_decode (
    // Clock and reset
    input wire sys_clk_i,
    input wire arst_n_i,
    // Step command from the queue
    input wire step_valid_i,
    input wire [3:0] step_opcode_i,
    input wire [3:0] step_arg_i,
    output wire step_done_o,
    // Peripheral event inputs
    input wire pwm_special_evt_i,
    input wire pwm_tb_sync_i,
    input wire [2:0] pwm_gen_irq_i,
    input wire [1:0] compare_unit_evt_i,
    input wire capture_unit_1_evt_i,
    input wire [3:0] analog_comparator_evt_i,
    input wire adc_done_i,
    input wire ext_interrupt_pin_2_i,
    // Sequencer interrupt pulses
    output wire [3:0] seq_irq_o,
    // Full trigger vector and named fan-out
    output wire [31:0] seq_trigger_out_o,
    output wire [3:0] compare_sync_o,
    output wire [3:0] compare_clk_o,
    output wire [3:0] capture_sync_o,
    output wire [3:0] adc_sample_trig_o,
    output wire [1:0] pwm_tb_src_o,
    output wire [1:0] cmp_blank_mask_o,
    output wire [1:0] pin_remap_select_o
);
    localparam ST_IDLE = 2'b01;
    localparam ST_WAIT = 2'b10;

    wire [15:0] evt_raw;
    wire [15:0] evt_rise;
    wire [15:0] evt_fall;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [3:0] wait_arg_r;
    reg wait_fall_r;
    reg [31:0] trig_r;
    reg [31:0] trig_nxt;
    reg [3:0] irq_r;
    reg [3:0] irq_nxt;
    reg done_r;
    reg done_nxt;
    wire edge_hit;
    wire [4:0] trig_idx;
    wire [31:0] trig_sel;
    wire [3:0] irq_sel;
    wire [15:0] src_hit;

    // Event selection table by argument value, reserved slots tied low
    assign evt_raw[`TSQ_ARG_SPECIAL_EVT] = pwm_special_evt_i;
    assign evt_raw[`TSQ_ARG_TB_SYNC] = pwm_tb_sync_i;
    assign evt_raw[`TSQ_ARG_PWM1] = pwm_gen_irq_i[0];
    assign evt_raw[`TSQ_ARG_PWM2] = pwm_gen_irq_i[1];
    assign evt_raw[`TSQ_ARG_PWM3] = pwm_gen_irq_i[2];
    assign evt_raw[`TSQ_ARG_RSV5] = 1'b0;
    assign evt_raw[`TSQ_ARG_RSV6] = 1'b0;
    assign evt_raw[`TSQ_ARG_CMP_UNIT1] = compare_unit_evt_i[0];
    assign evt_raw[`TSQ_ARG_CMP_UNIT2] = compare_unit_evt_i[1];
    assign evt_raw[`TSQ_ARG_CAP_UNIT1] = capture_unit_1_evt_i;
    assign evt_raw[`TSQ_ARG_ACMP1] = analog_comparator_evt_i[0];
    assign evt_raw[`TSQ_ARG_ACMP2] = analog_comparator_evt_i[1];
    assign evt_raw[`TSQ_ARG_ACMP3] = analog_comparator_evt_i[2];
    assign evt_raw[`TSQ_ARG_ACMP4] = analog_comparator_evt_i[3];
    assign evt_raw[`TSQ_ARG_ADC_DONE] = adc_done_i;
    assign evt_raw[`TSQ_ARG_EXT_EXT_INTERRUPT_PIN_2] = ext_interrupt_pin_2_i;

    // One synchroniser and edge detector per event input
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_evt
            tsq_edge_detect u_edge (
                .sys_clk_i(sys_clk_i),
                .arst_n_i(arst_n_i),
                .evt_i(evt_raw[gi]),
                .rise_o(evt_rise[gi]),
                .fall_o(evt_fall[gi])
            );
        end
    endgenerate

    // Command class decode from the opcode nibble
    wire cmd_wait_rise;
    wire cmd_wait_fall;
    wire cmd_wait;
    wire cmd_irq;
    wire cmd_trig;

    // Opcodes outside these classes belong to other blocks and get no done
    assign cmd_wait_rise = (step_opcode_i == `TSQ_OP_WAIT_RISE);
    assign cmd_wait_fall = (step_opcode_i == `TSQ_OP_WAIT_FALL);
    assign cmd_wait = cmd_wait_rise | cmd_wait_fall;
    assign cmd_irq = (step_opcode_i == `TSQ_OP_IRQ);
    assign cmd_trig = (step_opcode_i[3:1] == `TSQ_OP_TRIG_HI);

    // Reserved wait slots and the live interrupt range
    wire arg_wait_rsv;
    wire arg_irq_live;

    assign arg_wait_rsv = (step_arg_i == `TSQ_ARG_RSV5) || (step_arg_i == `TSQ_ARG_RSV6);
    assign arg_irq_live = (step_arg_i <= `TSQ_IRQ_LAST);

    // A step is taken only while idle; a waiting sequencer ignores the queue
    wire idle;
    wire take;

    assign idle = (state_r == ST_IDLE);
    assign take = idle & step_valid_i;

    // Trigger index is the low opcode bit above the argument
    assign trig_idx = {step_opcode_i[0], step_arg_i};

    // Per-output trigger decode; reserved indices are tied low and never fire
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_trig
            if (gi >= `TSQ_TRIG_RSV_LO && gi <= `TSQ_TRIG_RSV_HI) begin : g_rsv
                assign trig_sel[gi] = 1'b0;
            end else begin : g_live
                assign trig_sel[gi] = take & cmd_trig & ({27'h0, trig_idx} == gi);
            end
        end
    endgenerate

    // Per-line interrupt decode for arguments inside the live range
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq
            assign irq_sel[gi] = take & cmd_irq & arg_irq_live &
                ({30'h0, step_arg_i[1:0]} == gi);
        end
    endgenerate

    // Steps that finish at once: interrupt, trigger and reserved wait slots
    wire done_now;

    assign done_now = take & (cmd_irq | cmd_trig | (cmd_wait & arg_wait_rsv));

    // Per-source edge hit: only the captured source in the captured sense counts
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_hit
            assign src_hit[gi] = ({28'h0, wait_arg_r} == gi) &&
                (wait_fall_r ? evt_fall[gi] : evt_rise[gi]);
        end
    endgenerate

    // Any hit ends the wait; edges seen before the wait was taken are lost
    assign edge_hit = |src_hit;

    // Wait state machine: enter on a live wait, leave on the selected edge
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take && cmd_wait && !arg_wait_rsv) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (edge_hit) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Next pulse values; every pulse is held for a single clock
    always @* begin
        trig_nxt = trig_sel;
        irq_nxt = irq_sel;
        done_nxt = done_now | ((state_r == ST_WAIT) & edge_hit);
    end

    // State register
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Capture the watched source and edge sense when a wait is taken
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_arg_r <= 4'h0;
            wait_fall_r <= 1'b0;
        end else if (take && cmd_wait) begin
            wait_arg_r <= step_arg_i;
            wait_fall_r <= cmd_wait_fall;
        end
    end

    // Pulse registers for triggers, interrupts and completion
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trig_r <= 32'h0000_0000;
            irq_r <= 4'h0;
            done_r <= 1'b0;
        end else begin
            trig_r <= trig_nxt;
            irq_r <= irq_nxt;
            done_r <= done_nxt;
        end
    end

    // Named fan-out flops: each peripheral route gets its own driver,
    // loaded from the same next value so it stays in step with the vector
    reg [3:0] cmp_sync_r;
    reg [3:0] cmp_clk_r;
    reg [3:0] cap_sync_r;
    reg [3:0] adc_trig_r;
    reg [1:0] pwm_src_r;
    reg [1:0] blank_mask_r;
    reg [1:0] remap_sel_r;

    // Fan-out registers
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmp_sync_r <= 4'h0;
            cmp_clk_r <= 4'h0;
            cap_sync_r <= 4'h0;
            adc_trig_r <= 4'h0;
            pwm_src_r <= 2'h0;
            blank_mask_r <= 2'h0;
            remap_sel_r <= 2'h0;
        end else begin
            cmp_sync_r <= trig_nxt[3:0];
            cmp_clk_r <= trig_nxt[7:4];
            cap_sync_r <= trig_nxt[11:8];
            adc_trig_r <= trig_nxt[15:12];
            pwm_src_r <= trig_nxt[17:16];
            blank_mask_r <= trig_nxt[19:18];
            remap_sel_r <= trig_nxt[31:30];
        end
    end

    // Completion, interrupts and the full trigger vector
    assign step_done_o = done_r;
    assign seq_irq_o = irq_r;
    assign seq_trigger_out_o = trig_r;

    // Named peripheral routes
    assign compare_sync_o = cmp_sync_r;
    assign compare_clk_o = cmp_clk_r;
    assign capture_sync_o = cap_sync_r;
    assign adc_sample_trig_o = adc_trig_r;
    assign pwm_tb_src_o = pwm_src_r;
    assign cmp_blank_mask_o = blank_mask_r;
    assign pin_remap_select_o = remap_sel_r;
endmodule // tsq_option_decode
